/* File: pkg/temp_unit_pkg.sv */
// Constants, types and helpers of the temperature unit and correction block
package temp_unit_pkg;

  // ******************************************************
  // Value format and carriers
  // ******************************************************
  localparam int FRAC_W = 16;
  localparam int CH_W = 2;

  typedef struct packed
  {
    logic [CH_W-1:0] ch;
    logic signed [31:0] value;
  } sample_t;

  typedef struct packed
  {
    logic signed [31:0] one_off;
    logic signed [31:0] lo_off;
    logic signed [31:0] hi_off;
    logic signed [31:0] ref_lo;
    logic signed [31:0] ref_hi;
  } chan_cfg_t;

  typedef enum logic [1:0]
  {
    ST_RUN = 2'b01,
    ST_RESTART = 2'b10
  } life_t;

  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [4:0] OFS_UNIT = 5'h00;
  localparam logic [4:0] OFS_ONE = 5'h04;
  localparam logic [4:0] OFS_LO_OFF = 5'h08;
  localparam logic [4:0] OFS_HI_OFF = 5'h0C;
  localparam logic [4:0] OFS_REF_LO = 5'h10;
  localparam logic [4:0] OFS_REF_HI = 5'h14;
  localparam logic [11:0] CTRL_ADDR = 12'h100;
  localparam logic [11:0] STAT_ADDR = 12'h104;
  localparam int CTRL_COMMIT_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_UNIT_LSB = 4;
  localparam int STAT_NCH_LSB = 8;
  localparam logic UNIT_CELSIUS = 1'b0;
  localparam logic UNIT_FAHR = 1'b1;
  localparam logic UNIT_RESET = UNIT_CELSIUS;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESTART_NS = 1000;
  localparam int RESTART_CYC =
    (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ******************************************************
  // Arithmetic
  // ******************************************************
  // 1.8 kept as the exact ratio 9/5 to avoid a rounded factor
  localparam logic signed [71:0] FAHR_NUM = 72'sh9;
  localparam logic signed [71:0] FAHR_DEN = 72'sh5;
  localparam int FAHR_ADD_DEG = 32;
  localparam logic signed [71:0] FAHR_OFS = 72'(FAHR_ADD_DEG) <<< FRAC_W;
  localparam logic signed [71:0] SAT_HI = 72'sh00_0000_0000_7FFF_FFFF;
  localparam logic signed [71:0] SAT_LO = 72'shFF_FFFF_FFFF_8000_0000;

  // Clamp a wide result into the Q16.16 range
  function automatic logic signed [31:0] sat32(input logic signed [71:0] v);
    if (v > SAT_HI)
      return SAT_HI[31:0];
    else if (v < SAT_LO)
      return SAT_LO[31:0];
    return v[31:0];
  endfunction

  // Celsius to Fahrenheit in Q16.16
  function automatic logic signed [31:0] to_fahr(input logic signed [31:0] c);
    return sat32((72'(c) * FAHR_NUM) / FAHR_DEN + FAHR_OFS);
  endfunction

endpackage

/* File: hw/temp_correct.sv */
// Two-stage unit conversion and correction pipeline for one sample
`timescale 1ns/100ps
`default_nettype none
module temp_correct
  import temp_unit_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire sample_t in_i,
  input wire chan_cfg_t cfg_i,
  input wire logic unit_i,
  output logic out_valid_o,
  output sample_t out_o
);

  // ******************************************************
  // Stage 1: unit conversion
  // ******************************************************
  logic s1_valid_r;
  sample_t s1_r;
  chan_cfg_t s1_cfg_r;
  logic signed [71:0] span;
  logic signed [71:0] acc;
  logic two_on;

  // Settings are sampled with the reading so later writes cannot tear it
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s1_valid_r <= 1'b0;
      s1_r <= '0;
      s1_cfg_r <= '0;
    end
    else
    begin
      s1_valid_r <= in_valid_i;
      if (in_valid_i)
      begin
        s1_r.ch <= in_i.ch;
        // Celsius stays internal, Fahrenheit only on request
        if (unit_i == UNIT_FAHR)
          s1_r.value <= to_fahr(in_i.value);
        else
          s1_r.value <= in_i.value;
        s1_cfg_r <= cfg_i;
      end
    end
  end

  // ******************************************************
  // Stage 2: one-point and two-point correction
  // ******************************************************
  // Offsets are in the output unit, so correct the converted value
  always_comb
  begin
    span = 72'(s1_cfg_r.ref_hi) - 72'(s1_cfg_r.ref_lo);
    two_on = (span != 72'sh0);
    acc = 72'(s1_r.value) + 72'(s1_cfg_r.one_off);
    if (two_on)
      acc = acc + 72'(s1_cfg_r.lo_off)
          + ((72'(s1_cfg_r.hi_off) - 72'(s1_cfg_r.lo_off))
          * (72'(s1_r.value) - 72'(s1_cfg_r.ref_lo))) / span;
  end

  // Clamp only at the format limit, range unchanged by correction
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      out_valid_o <= 1'b0;
      out_o <= '0;
    end
    else
    begin
      out_valid_o <= s1_valid_r;
      if (s1_valid_r)
      begin
        out_o.ch <= s1_r.ch;
        out_o.value <= sat32(acc);
      end
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  a_fahr_conv:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    in_valid_i && unit_i == UNIT_FAHR
    |=> s1_r.value == to_fahr($past(in_i.value)))
    else $error("Fahrenheit conversion wrong");

  a_celsius_pass:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    in_valid_i && unit_i == UNIT_CELSIUS |=> s1_r.value == $past(in_i.value))
    else $error("Celsius value altered");

  a_one_point_only:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    s1_valid_r && s1_cfg_r.ref_hi == s1_cfg_r.ref_lo
    |=> out_valid_o && out_o.value == sat32(72'($past(s1_r.value))
        + 72'($past(s1_cfg_r.one_off))))
    else $error("One-point result wrong");

  a_two_point_low:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    s1_valid_r && two_on && s1_r.value == s1_cfg_r.ref_lo
    |=> out_o.value == sat32(72'($past(s1_r.value))
        + 72'($past(s1_cfg_r.one_off)) + 72'($past(s1_cfg_r.lo_off))))
    else $error("Lower point offset wrong");

  a_two_point_high:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    s1_valid_r && two_on && s1_r.value == s1_cfg_r.ref_hi
    |=> out_o.value == sat32(72'($past(s1_r.value))
        + 72'($past(s1_cfg_r.one_off)) + 72'($past(s1_cfg_r.hi_off))))
    else $error("Higher point offset wrong");

endmodule
`default_nettype wire

/* File: hw/temp_unit_top.sv */
// Temperature unit selection and input correction with AHB-Lite settings
`timescale 1ns/100ps
`default_nettype none
module temp_unit_top
  import temp_unit_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int RESTART_CYCLES = RESTART_CYC
)(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic sample_valid_i,
  input wire sample_t sample_i,
  output logic sample_ready_o,
  output logic result_valid_o,
  output sample_t result_o
);

  // ******************************************************
  // Declarations
  // ******************************************************
  life_t state_r;
  logic [15:0] rst_cnt_r;
  logic [NUM_CH-1:0] unit_stage_r;
  logic [NUM_CH-1:0] unit_act_r;
  chan_cfg_t cfg_r [NUM_CH];
  logic [11:0] addr_r;
  logic wr_phase_r;
  logic rd_phase_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic accept;
  logic commit_w;
  logic chan_wr;
  logic dp_valid;
  logic [15:0] stall_len_r;

  // Channel window decode, shared by reads and writes
  function automatic logic is_chan(input logic [11:0] a);
    return (a[11:7] == 5'h00) && (int'(a[6:5]) < NUM_CH);
  endfunction

  // ******************************************************
  // AHB-Lite slave
  // ******************************************************
  // Only the low 12 address bits decode, so the map aliases upward
  assign accept = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = !rd_phase_r;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
  assign chan_wr = wr_phase_r && is_chan(addr_r);
  assign commit_w = wr_phase_r && addr_r == CTRL_ADDR
                    && hwdata_i[CTRL_COMMIT_BIT];

  // Address phase capture; size ignored, whole words only
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      addr_r <= '0;
      wr_phase_r <= 1'b0;
      rd_phase_r <= 1'b0;
    end
    else
    begin
      wr_phase_r <= accept && hwrite_i;
      rd_phase_r <= accept && !hwrite_i;
      if (accept)
        addr_r <= haddr_i[11:0];
    end
  end

  // Reads take one wait state so read data leaves a flip-flop
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      hrdata_r <= '0;
    else if (rd_phase_r)
      hrdata_r <= rd_mux;
  end

  // ******************************************************
  // Channel settings
  // ******************************************************
  // Offsets and points go live at once; only the unit is staged
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      unit_stage_r <= {NUM_CH{UNIT_RESET}};
      for (int i = 0; i < NUM_CH; i++)
        cfg_r[i] <= '0;
    end
    else if (chan_wr)
    begin
      case (addr_r[4:0])
        OFS_UNIT: unit_stage_r[addr_r[6:5]] <= hwdata_i[0];
        OFS_ONE: cfg_r[addr_r[6:5]].one_off <= hwdata_i;
        OFS_LO_OFF: cfg_r[addr_r[6:5]].lo_off <= hwdata_i;
        OFS_HI_OFF: cfg_r[addr_r[6:5]].hi_off <= hwdata_i;
        OFS_REF_LO: cfg_r[addr_r[6:5]].ref_lo <= hwdata_i;
        OFS_REF_HI: cfg_r[addr_r[6:5]].ref_hi <= hwdata_i;
        default: ;
      endcase
    end
  end

  // ******************************************************
  // Restart sequencer
  // ******************************************************
  // A commit during a restart is dropped; the running restart
  // already picks up the latest staged units at its end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_r <= ST_RUN;
      rst_cnt_r <= '0;
      unit_act_r <= {NUM_CH{UNIT_RESET}};
    end
    else
    begin
      case (state_r)
        ST_RUN:
        begin
          if (commit_w)
          begin
            state_r <= ST_RESTART;
            rst_cnt_r <= 16'(RESTART_CYCLES - 1);
          end
        end
        ST_RESTART:
        begin
          if (rst_cnt_r == 16'h0000)
          begin
            state_r <= ST_RUN;
            unit_act_r <= unit_stage_r;
          end
          else
            rst_cnt_r <= rst_cnt_r - 16'h0001;
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // ******************************************************
  // Read mux
  // ******************************************************
  // Unused and unmapped bits read as zero
  always_comb
  begin
    rd_mux = '0;
    if (is_chan(addr_r))
    begin
      case (addr_r[4:0])
        OFS_UNIT: rd_mux[0] = unit_stage_r[addr_r[6:5]];
        OFS_ONE: rd_mux = cfg_r[addr_r[6:5]].one_off;
        OFS_LO_OFF: rd_mux = cfg_r[addr_r[6:5]].lo_off;
        OFS_HI_OFF: rd_mux = cfg_r[addr_r[6:5]].hi_off;
        OFS_REF_LO: rd_mux = cfg_r[addr_r[6:5]].ref_lo;
        OFS_REF_HI: rd_mux = cfg_r[addr_r[6:5]].ref_hi;
        default: rd_mux = '0;
      endcase
    end
    else if (addr_r == STAT_ADDR)
    begin
      rd_mux[STAT_BUSY_BIT] = (state_r == ST_RESTART);
      rd_mux[STAT_UNIT_LSB +: NUM_CH] = unit_act_r;
      rd_mux[STAT_NCH_LSB +: 8] = 8'(NUM_CH);
    end
  end

  // ******************************************************
  // Sample path
  // ******************************************************
  // Samples stall during restart; bad channel numbers are dropped
  assign sample_ready_o = (state_r == ST_RUN);
  assign dp_valid = sample_valid_i && sample_ready_o
                    && (int'(sample_i.ch) < NUM_CH);

  temp_correct u_correct
  (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(dp_valid),
    .in_i(sample_i),
    .cfg_i(cfg_r[sample_i.ch]),
    .unit_i(unit_act_r[sample_i.ch]),
    .out_valid_o(result_valid_o),
    .out_o(result_o)
  );

  // ******************************************************
  // Checks
  // ******************************************************
  a_unit_held:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    !(state_r == ST_RESTART && rst_cnt_r == 16'h0000)
    |=> $stable(unit_act_r))
    else $error("Active unit changed outside restart");

  a_restart_apply:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == ST_RESTART && rst_cnt_r == 16'h0000
    |=> unit_act_r == $past(unit_stage_r) && sample_ready_o)
    else $error("Restart did not apply staged unit");

  a_auto_restart:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    commit_w && state_r == ST_RUN
    |=> state_r == ST_RESTART && !sample_ready_o
        && rst_cnt_r == 16'(RESTART_CYCLES - 1))
    else $error("Commit did not start restart");

  a_offset_live:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    chan_wr && addr_r[4:0] == OFS_ONE && state_r == ST_RUN
    |=> state_r == ST_RUN
        && cfg_r[$past(addr_r[6:5])].one_off == $past(hwdata_i))
    else $error("Offset write not applied at once");

  a_read_wait:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("Read wait state wrong");

  a_write_nowait:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && hwrite_i |=> hreadyout_o && hresp_o == 1'b0)
    else $error("Write data phase stalled");

  // Staged unit moves only on its own bus write
  a_stage_write:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    chan_wr && addr_r[4:0] == OFS_UNIT
    |=> unit_stage_r[$past(addr_r[6:5])] == $past(hwdata_i[0]))
    else $error("Unit setting not stored");

  a_stage_idle:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    !chan_wr |=> $stable(unit_stage_r))
    else $error("Staged unit changed without a write");

  // Correction settings reach the next sample, no restart needed
  a_lo_live:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    chan_wr && addr_r[4:0] == OFS_LO_OFF
    |=> cfg_r[$past(addr_r[6:5])].lo_off == $past(hwdata_i))
    else $error("Lower offset write not applied at once");

  a_ref_live:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    chan_wr && addr_r[4:0] == OFS_REF_HI
    |=> cfg_r[$past(addr_r[6:5])].ref_hi == $past(hwdata_i))
    else $error("Reference point write not applied at once");

  // A commit inside a restart must not reload the countdown
  a_restart_count:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == ST_RESTART && rst_cnt_r != 16'h0000
    |=> state_r == ST_RESTART && rst_cnt_r == $past(rst_cnt_r) - 16'h0001)
    else $error("Restart countdown disturbed");

  a_status_unit:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_phase_r && addr_r == STAT_ADDR
    |=> hrdata_o[STAT_UNIT_LSB +: NUM_CH] == $past(unit_act_r))
    else $error("Status shows wrong active units");

  // Fixed two-cycle latency, channel number carried through
  a_result_lat:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    dp_valid |-> ##2 (result_valid_o
        && result_o.ch == $past(sample_i.ch, 2)))
    else $error("Result latency wrong");

  // ******************************************************
  // Restart length monitor
  // ******************************************************
  // Counts stalled cycles, since a long repetition would slow the checker
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      stall_len_r <= '0;
    else if (sample_ready_o)
      stall_len_r <= '0;
    else
      stall_len_r <= stall_len_r + 16'h0001;
  end

  a_restart_len:
  assert property (@(posedge mclk_i) disable iff (reset_i)
    !sample_ready_o ##1 sample_ready_o
    |-> stall_len_r == 16'(RESTART_CYCLES))
    else $error("Restart length wrong");

endmodule
`default_nettype wire

/* File: verification/sensor_src.sv */
// Sensor-side source model feeding Celsius samples into the block
`timescale 1ns/100ps
`default_nettype none
module sensor_src
  import temp_unit_pkg::*;
(
  input wire logic mclk_i,
  input wire logic ready_i,
  output logic valid_o,
  output sample_t smp_o
);

  // Idle lines start low before the first sample
  initial
  begin
    valid_o = 1'b0;
    smp_o = '0;
  end

  // ******************************************************
  // One sample: optional idle gap, then held until taken or 50 edges pass
  // ******************************************************
  // Readings are raw Celsius in Q16.16, as the sensor side supplies them
  task automatic send(input logic [CH_W-1:0] ch, input logic [31:0] v,
                      input int gap, output bit ok);
    int k;
    repeat (gap + 1) @(posedge mclk_i);
    valid_o <= 1'b1;
    smp_o <= {ch, v};
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (ready_i !== 1'b1 && k < 50);
    ok = (ready_i === 1'b1);
    valid_o <= 1'b0;
    // Stale data would hide a late capture, so show its inverse
    smp_o <= ~smp_o;
  endtask

endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for unit selection and input correction
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import temp_unit_pkg::*;
();
  localparam int RST_CYC = 4;
  localparam int BOUND = 50;
  localparam longint DEG = 65536;

  logic mclk, reset, hsel, hwrite, hready, hresp;
  logic s_valid, s_ready, r_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  sample_t smp, res;
  int n_errors = 0;
  int compares = 0;

  temp_unit_top #(.NUM_CH(4), .RESTART_CYCLES(RST_CYC)) dut_u (
    .mclk_i(mclk), .reset_i(reset), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .sample_valid_i(s_valid),
    .sample_i(smp), .sample_ready_o(s_ready), .result_valid_o(r_valid),
    .result_o(res));

  sensor_src src_u (.mclk_i(mclk), .ready_i(s_ready), .valid_o(s_valid),
    .smp_o(smp));

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ******************************************************
  // Reporting
  // ******************************************************
  task automatic complete_run();
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask

  // ******************************************************
  // Bus master and sample helpers
  // ******************************************************
  // Holds the current phase until hready is seen high at an edge
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (hready !== 1'b1 && k < BOUND);
    if (hready !== 1'b1)
      tmo();
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    chk(32'(hresp), 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic put(input int ch, input logic [4:0] ofs, input longint d);
    logic [31:0] q;
    bus(1'b1, 12'(ch) * CH_STRIDE + {7'h0, ofs}, 32'(d), q);
  endtask

  // Result comes a fixed two edges after capture; bounded wait anyway
  task automatic samp(input int ch, input longint x, input int gap,
                      output logic [31:0] v);
    bit ok;
    int k;
    src_u.send(2'(ch), 32'(x), gap, ok);
    if (!ok)
      tmo();
    k = 0;
    while (r_valid !== 1'b1 && k < BOUND)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (r_valid !== 1'b1)
      tmo();
    chk(32'(res.ch), 32'(ch));
    v = res.value;
  endtask

  // Reference arithmetic, worked out independently in wide integers
  function automatic logic [31:0] exp_val(input logic u, input longint x,
    input longint one, input longint lo, input longint hi,
    input longint rl, input longint rh);
    longint y, a;
    y = u ? (x * 9) / 5 + 32 * DEG : x;
    a = y + one;
    if (rh != rl)
      a = a + lo + ((hi - lo) * (y - rl)) / (rh - rl);
    return a[31:0];
  endfunction

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic t_reset();
    logic [31:0] q;
    rd(STAT_ADDR, q);
    chk(q, 32'h0000_0400);
    rd(12'h0FC, q);
    chk(q, 32'h0);
    put(0, OFS_UNIT, 2);
    rd(12'h000, q);
    chk(q, 32'h0);
  endtask

  task automatic t_one();
    longint xs[3] = '{-200 * DEG, 0, 1300 * DEG};
    logic [31:0] v;
    put(0, OFS_ONE, 'h13333);
    foreach (xs[i])
    begin
      samp(0, xs[i], 0, v);
      chk(v, exp_val(1'b0, xs[i], 'h13333, 0, 0, 0, 0));
    end
  endtask

  // Staged unit stays idle until commit; restart stalls the far side
  task automatic t_unit();
    logic [31:0] q, v;
    int k;
    put(1, OFS_UNIT, 1);
    samp(1, 100 * DEG, 2, v);
    chk(v, 32'(100 * DEG));
    rd(STAT_ADDR, q);
    chk(q, 32'h0000_0400);
    bus(1'b1, CTRL_ADDR, 32'h1 << CTRL_COMMIT_BIT, q);
    k = 0;
    fork
      begin
        #1;
        while (s_ready !== 1'b1 && k < BOUND)
        begin
          @(posedge mclk);
          #1;
          k++;
        end
      end
      samp(1, 100 * DEG, 0, v);
    join
    chk(32'(k), 32'(RST_CYC));
    chk(v, 32'(212 * DEG));
    rd(STAT_ADDR, q);
    chk(q, 32'h0000_0420);
  endtask

  // Points set to references, offsets to reference minus reading
  task automatic t_two();
    longint xs[4] = '{0, 50 * DEG, 100 * DEG, -40 * DEG};
    logic [31:0] v;
    put(1, OFS_ONE, DEG / 2);
    put(1, OFS_REF_LO, 32 * DEG);
    put(1, OFS_REF_HI, 212 * DEG);
    put(1, OFS_LO_OFF, DEG);
    put(1, OFS_HI_OFF, 3 * DEG);
    foreach (xs[i])
    begin
      samp(1, xs[i], 0, v);
      chk(v, exp_val(1'b1, xs[i], DEG / 2, DEG, 3 * DEG, 32 * DEG,
        212 * DEG));
    end
  endtask

  // Equal points, zero or not, leave two-point correction off
  task automatic t_none();
    longint rv[2] = '{0, 10 * DEG};
    logic [31:0] v;
    put(2, OFS_LO_OFF, 5 * DEG);
    put(2, OFS_HI_OFF, 7 * DEG);
    foreach (rv[i])
    begin
      put(2, OFS_REF_LO, rv[i]);
      put(2, OFS_REF_HI, rv[i]);
      samp(2, 20 * DEG, 0, v);
      chk(v, 32'(20 * DEG));
    end
  endtask

  // Mid-run reset drops staged and active units back to Celsius
  task automatic t_rerun();
    logic [31:0] q, v;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(STAT_ADDR, q);
    chk(q, 32'h0000_0400);
    rd(12'h020, q);
    chk(q, 32'h0);
    samp(1, 100 * DEG, 0, v);
    chk(v, 32'(100 * DEG));
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_one();
    t_unit();
    t_two();
    t_none();
    t_rerun();
    complete_run();
  end

endmodule
`default_nettype wire
